// ### wss_regs.svh
// Register map, field positions, codes and reset values of the waveform unit.
//
// Notes on behaviour
// - Asynchronous input edges shift dead band one clock.
// - Direction bit applies at next rising input.
// - Direction change delays new modulated output once.
// - Steering: unselected outputs fixed, selected carry input.
// - Polarity applies only to steered outputs.
// - Shutdown overrides only steered outputs.
// - Mode 000: steering write acts at once.
// - Mode 001: steering change waits rising input.
// - Software shutdown bit holds shutdown while set.
// - Auto-restart clears software shutdown in hardware.
// - Enabled fault input forces override levels at the next clock.
// - Six shutdown sources, all active low.
// - Faults are level sensed; shutdown persists until cleared.
// - Fast oscillator kept running while unit active.
// - Override fields set pair levels, polarity used only by the inactive-level code.
// - Software clear refused while fault still active.
// - Overrides stay until first rising input after clear.
// - Auto-restart clears shutdown once faults go away.
// - Load bit loads dead bands on next input edge.
// - Mode field decodes six modes, two reserved.
// - Override codes: one, zero, float, inactive level.
// - Two 6-bit dead-band counters count clock periods.
// - Half-bridge: A true, B inverted, dead band between.
// - Full-bridge forward and reverse static/modulated outputs.
`ifndef WSS_REGS_SVH
`define WSS_REGS_SVH

`define ADDR_CTRL0      3'h0
`define ADDR_POL        3'h1
`define ADDR_DBR        3'h2
`define ADDR_DBF        3'h3
`define ADDR_AS0        3'h4
`define ADDR_AS1        3'h5
`define ADDR_STEER      3'h6
`define ADDR_CLK        3'h7

`define BIT_EN          7
`define BIT_LD          6
`define BIT_SHUT        7
`define BIT_REN         6
`define BIT_IN          5

`define MODE_STEER      3'h0
`define MODE_SYNC       3'h1
`define MODE_FWD        3'h2
`define MODE_REV        3'h3
`define MODE_HALF       3'h4
`define MODE_PUSH       3'h5

`define LVL_ONE         2'h3
`define LVL_ZERO        2'h2
`define LVL_FLOAT       2'h1
`define LVL_INACT       2'h0

`define OVERRIDE_LEVEL_BD_RESET      2'h1
`define OVERRIDE_LEVEL_AC_RESET      2'h1
`define AS1_TOP_BIT     8'h80
`define DB_ZERO         6'h00

`endif

// ### wss_pkg.sv
// Types shared by the waveform steering and shutdown block.
package wss_pkg;

    // Drive state of the four output pins; oe_n low means the pin is driven.
    typedef struct packed {
        logic [3:0] level;
        logic [3:0] oe_n;
    } pin_drive_t;

    // Run state of the output stage.
    typedef enum logic [1:0] {
        ST_OFF,
        ST_HOLD,
        ST_RUN
    } run_state_t;

endpackage

// ### waveform_steering_shutdown.sv
// Complementary waveform unit: modes, steering, dead band and auto-shutdown.
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "wss_regs.svh"

module waveform_steering_shutdown (
    input  wire logic               i_mclk,
    input  wire logic               i_reset_n,
    input  wire logic [2:0]         i_addr,
    input  wire logic [7:0]         i_wdata,
    input  wire logic               i_wr,
    input  wire logic               i_rd,
    input  wire logic               i_data,
    input  wire logic [5:0]         i_shutdown_n,
    output logic [7:0]              o_rdata,
    output wss_pkg::pin_drive_t     o_pins,
    output logic                    o_keep_fast_osc
);
    import wss_pkg::*;

    // ------------------------------------------------------------
    // Register storage and decode
    // ------------------------------------------------------------
    logic       en;
    logic       ld;
    logic [2:0] mode;
    logic [3:0] pol;
    logic [5:0] dbr_w;
    logic [5:0] dbf_w;
    logic [5:0] dbr;
    logic [5:0] dbf;
    logic       shut;
    logic       ren;
    logic [1:0] override_level_bd;
    logic [1:0] override_level_ac;
    logic [5:0] as_en;
    logic [3:0] str_w;
    logic [3:0] str_act;
    logic       clk_sel;
    logic       data_q;
    logic       rise;
    logic       fall;
    logic       ext_fault;
    logic       ovr;
    logic       dir;
    logic       hold_mod;
    logic [5:0] dcnt;
    logic [5:0] rcnt;
    logic [5:0] fcnt;
    logic       pp;
    logic       act_seen;
    logic [3:0] raw;
    logic [3:0] mod;
    run_state_t state;
    run_state_t next_state;

    logic wr_ctrl;
    logic wr_pol;
    logic wr_dbr;
    logic wr_dbf;
    logic wr_as0;
    logic wr_as1;
    logic wr_steer;
    logic wr_clk;

    // Write strobes per register.
    assign wr_ctrl  = i_wr && (i_addr == `ADDR_CTRL0);
    assign wr_pol   = i_wr && (i_addr == `ADDR_POL);
    assign wr_dbr   = i_wr && (i_addr == `ADDR_DBR);
    assign wr_dbf   = i_wr && (i_addr == `ADDR_DBF);
    assign wr_as0   = i_wr && (i_addr == `ADDR_AS0);
    assign wr_as1   = i_wr && (i_addr == `ADDR_AS1);
    assign wr_steer = i_wr && (i_addr == `ADDR_STEER);
    assign wr_clk   = i_wr && (i_addr == `ADDR_CLK);

    // Input edges and the combined fault level; faults are sensed by level, not edge.
    assign rise      = i_data && !data_q;
    assign fall      = !i_data && data_q;
    assign ext_fault = |(as_en & ~i_shutdown_n);
    assign ovr       = (state == ST_HOLD) || shut || ext_fault;

    // ------------------------------------------------------------
    // Plain configuration registers
    // ------------------------------------------------------------
    // Mode decode is fixed at write time; reserved codes drive nothing active.
    always_ff @(posedge i_mclk)
    begin
        if (!i_reset_n)
        begin
            en      <= 1'b0;
            mode    <= `MODE_STEER;
            pol     <= 4'h0;
            dbr_w   <= `DB_ZERO;
            dbf_w   <= `DB_ZERO;
            ren     <= 1'b0;
            override_level_bd    <= `OVERRIDE_LEVEL_BD_RESET;
            override_level_ac    <= `OVERRIDE_LEVEL_AC_RESET;
            as_en   <= 6'h00;
            str_w   <= 4'h0;
            clk_sel <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                en   <= i_wdata[`BIT_EN];
                mode <= i_wdata[2:0];
            end
            if (wr_pol)
                pol <= i_wdata[3:0];
            if (wr_dbr)
                dbr_w <= i_wdata[5:0];
            if (wr_dbf)
                dbf_w <= i_wdata[5:0];
            if (wr_as0)
            begin
                ren  <= i_wdata[`BIT_REN];
                override_level_bd <= i_wdata[5:4];
                override_level_ac <= i_wdata[3:2];
            end
            if (wr_as1)
                as_en <= i_wdata[5:0];
            if (wr_steer)
                str_w <= i_wdata[3:0];
            if (wr_clk)
                clk_sel <= i_wdata[0];
        end
    end

    // Load request: only accepted once the unit is already enabled, cleared at the next input edge.
    always_ff @(posedge i_mclk)
    begin
        if (!i_reset_n)
            ld <= 1'b0;
        else if (wr_ctrl && i_wdata[`BIT_LD] && en)
            ld <= 1'b1;
        else if (ld && (rise || fall))
            ld <= 1'b0;
    end

    // Active dead-band values: written straight through while disabled, else on a load.
    always_ff @(posedge i_mclk)
    begin
        if (!i_reset_n)
        begin
            dbr <= `DB_ZERO;
            dbf <= `DB_ZERO;
        end
        else if (!en)
        begin
            dbr <= wr_dbr ? i_wdata[5:0] : dbr_w;
            dbf <= wr_dbf ? i_wdata[5:0] : dbf_w;
        end
        else if (ld && (rise || fall))
        begin
            dbr <= dbr_w;
            dbf <= dbf_w;
        end
    end

    // ------------------------------------------------------------
    // Shutdown status and run state
    // ------------------------------------------------------------
    // Set wins over any clear, so a fault is never lost to a software clear.
    always_ff @(posedge i_mclk)
    begin
        if (!i_reset_n)
            shut <= 1'b0;
        else if (ext_fault || (wr_as0 && i_wdata[`BIT_SHUT]))
            shut <= 1'b1;
        else if (wr_as0)
            shut <= 1'b0;
        else if (ren)
            shut <= 1'b0;
    end

    // Start-up always passes through the hold state, so the first pulse is whole.
    always_comb
    begin
        next_state = state;
        if (!en)
            next_state = ST_OFF;
        else if (shut || ext_fault)
            next_state = ST_HOLD;
        else
        begin
            unique case (state)
                ST_OFF:  next_state = ST_HOLD;
                ST_HOLD: next_state = rise ? ST_RUN : ST_HOLD;
                ST_RUN:  next_state = ST_RUN;
            endcase
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_reset_n)
            state <= ST_OFF;
        else
            state <= next_state;
    end

    // ------------------------------------------------------------
    // Input sampling and steering
    // ------------------------------------------------------------
    // Edges are seen on the module clock, hence one clock of dead-band jitter.
    always_ff @(posedge i_mclk)
    begin
        if (!i_reset_n)
            data_q <= 1'b0;
        else
            data_q <= i_data;
    end

    // Plain steering follows writes at once; synchronous steering waits for a rising edge.
    always_ff @(posedge i_mclk)
    begin
        if (!i_reset_n)
            str_act <= 4'h0;
        else if (mode == `MODE_STEER)
            str_act <= wr_steer ? i_wdata[3:0] : str_w;
        else if (rise)
            str_act <= str_w;
    end

    // ------------------------------------------------------------
    // Dead-band counters
    // ------------------------------------------------------------
    // Rising count runs while input is high, falling count while low.
    always_ff @(posedge i_mclk)
    begin
        if (!i_reset_n)
        begin
            rcnt <= `DB_ZERO;
            fcnt <= `DB_ZERO;
        end
        else
        begin
            if (rise)
                rcnt <= `DB_ZERO;
            else if (data_q && (rcnt < dbr))
                rcnt <= rcnt + 6'h01;
            if (fall)
                fcnt <= `DB_ZERO;
            else if (!data_q && (fcnt < dbf))
                fcnt <= fcnt + 6'h01;
        end
    end

    // Direction is taken at the rising edge; a change blanks the new modulated output once.
    always_ff @(posedge i_mclk)
    begin
        if (!i_reset_n)
        begin
            dir      <= 1'b0;
            hold_mod <= 1'b0;
            dcnt     <= `DB_ZERO;
        end
        else if (rise && (mode[2:1] == 2'h1))
        begin
            dir      <= mode[0];
            hold_mod <= (mode[0] != dir);
            dcnt     <= `DB_ZERO;
        end
        else if (hold_mod)
        begin
            if (dcnt >= (dir ? dbr : dbf))
                hold_mod <= 1'b0;
            else
                dcnt <= dcnt + 6'h01;
        end
    end

    // Push-pull sequencer restarts on disable or shutdown, first pulse on A.
    always_ff @(posedge i_mclk)
    begin
        if (!i_reset_n || !en || ovr)
            pp <= 1'b0;
        else if (fall && (mode == `MODE_PUSH))
            pp <= ~pp;
    end

    // Raw active-high waveforms and which outputs are open to shutdown and polarity.
    always_comb
    begin
        raw = 4'h0;
        mod = 4'hF;
        case (mode)
            `MODE_STEER, `MODE_SYNC:
            begin
                raw = {4{data_q}};
                mod = str_act;
            end
            `MODE_FWD, `MODE_REV:
            begin
                if (dir)
                    raw = {1'b0, 1'b1, data_q && !hold_mod, 1'b0};
                else
                    raw = {data_q && !hold_mod, 1'b0, 1'b0, 1'b1};
            end
            `MODE_HALF:
            begin
                raw[0] = data_q && (rcnt == dbr);
                raw[1] = !data_q && (fcnt == dbf);
                raw[2] = raw[0];
                raw[3] = raw[1];
            end
            `MODE_PUSH:
            begin
                raw[0] = data_q && !pp;
                raw[1] = data_q && pp;
                raw[2] = raw[0];
                raw[3] = raw[1];
            end
            default:
            begin
                raw = 4'h0;
                mod = 4'h0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Output stage, one flop pair per pin
    // ------------------------------------------------------------
    // Overrides are registered, so a fault reaches the pins one clock later.
    for (genvar i = 0; i < 4; i++)
    begin : g_out
        logic [1:0] lvl;
        assign lvl = (i % 2 == 0) ? override_level_ac : override_level_bd;
        always_ff @(posedge i_mclk)
        begin
            if (!i_reset_n || (state == ST_OFF && !ext_fault) || !en)
            begin
                o_pins.level[i] <= 1'b0;
                o_pins.oe_n[i]  <= 1'b1;
            end
            else if (!mod[i])
            begin
                o_pins.level[i] <= 1'b0;
                o_pins.oe_n[i]  <= 1'b0;
            end
            else if (ovr)
            begin
                o_pins.oe_n[i]  <= (lvl == `LVL_FLOAT);
                o_pins.level[i] <= (lvl == `LVL_ONE) ||
                                   ((lvl == `LVL_INACT) && pol[i]);
            end
            else
            begin
                o_pins.level[i] <= raw[i] ^ pol[i];
                o_pins.oe_n[i]  <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Read port and oscillator keep-alive
    // ------------------------------------------------------------
    // Read data stands only in the cycle after the strobe; unmapped bits read zero, except AS1 bit 7, which reads one.
    always_ff @(posedge i_mclk)
    begin
        if (!i_reset_n || !i_rd)
            o_rdata <= 8'h00;
        else
        begin
            case (i_addr)
                `ADDR_CTRL0: o_rdata <= {en, ld, 3'h0, mode};
                `ADDR_POL:   o_rdata <= {2'h0, data_q, 1'b0, pol};
                `ADDR_DBR:   o_rdata <= {2'h0, dbr_w};
                `ADDR_DBF:   o_rdata <= {2'h0, dbf_w};
                `ADDR_AS0:   o_rdata <= {shut, ren, override_level_bd, override_level_ac, 2'h0};
                `ADDR_AS1:   o_rdata <= `AS1_TOP_BIT | {2'h0, as_en};
                `ADDR_STEER: o_rdata <= {4'h0, str_w};
                default:     o_rdata <= {7'h00, clk_sel};
            endcase
        end
    end

    // Input counts as active once an edge is seen while enabled.
    always_ff @(posedge i_mclk)
    begin
        if (!i_reset_n || !en)
        begin
            act_seen        <= 1'b0;
            o_keep_fast_osc <= 1'b0;
        end
        else
        begin
            act_seen        <= act_seen || rise || fall;
            o_keep_fast_osc <= clk_sel && act_seen;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);

    AST_LD_NEEDS_EN: assert property ($rose(ld) |-> $past(en))
        else $error("load bit set while unit disabled");
    AST_LD_CLEARS: assert property (ld && (rise || fall) && !i_wr
        |=> !ld ##1 (!ld || $past(i_wr)))
        else $error("load bit not cleared by edge");
    AST_FAULT_SETS: assert property (ext_fault |=> shut)
        else $error("fault did not set shutdown");
    AST_FAULT_PIN: assert property (en && ext_fault && mode == `MODE_HALF
        && override_level_ac == `LVL_ZERO |=> !o_pins.level[0] && !o_pins.oe_n[0])
        else $error("override level not applied");
    AST_CLEAR_REFUSED: assert property (ext_fault && wr_as0 && !i_wdata[`BIT_SHUT]
        |=> shut)
        else $error("shutdown cleared during fault");
    AST_SW_HOLD: assert property (shut && !ren && !i_wr && !ext_fault |=> shut)
        else $error("shutdown dropped without restart");
    AST_AUTO_CLR: assert property (shut && ren && !ext_fault && !i_wr |=> !shut)
        else $error("auto-restart did not clear");
    AST_HOLD_TO_RISE: assert property (state == ST_HOLD && !rise |=> state != ST_RUN)
        else $error("left override before rising edge");
    AST_SYNC_STEER: assert property (mode == `MODE_SYNC && !rise
        && $past(mode) == `MODE_SYNC |=> $stable(str_act))
        else $error("synchronous steering changed between edges");
    AST_ASYNC_STEER: assert property (wr_steer && mode == `MODE_STEER
        |=> str_act == $past(i_wdata[3:0]))
        else $error("steering write not immediate");
    AST_DIR_AT_RISE: assert property (!rise |=> $stable(dir))
        else $error("direction changed off a rising edge");
    AST_FIXED_PIN: assert property (en && state != ST_OFF && mode == `MODE_STEER
        && !str_act[1] |=> !o_pins.level[1] && !o_pins.oe_n[1])
        else $error("fixed output disturbed");

    COV_AUTO_RESTART: cover property (shut && ren ##1 !shut ##[1:40] state == ST_RUN);
    COV_DIR_CHANGE: cover property ($rose(hold_mod) ##[1:70] $fell(hold_mod));
    COV_PUSH_PULL: cover property (mode == `MODE_PUSH && $rose(pp));

endmodule // waveform_steering_shutdown
`default_nettype wire

// ### pwm_source.sv
// Behavioural model of the on-chip PWM source that feeds the waveform unit.
`timescale 1ns/1ps
`default_nettype none

module pwm_source #(
    parameter int HIGH_CYCLES = 3,
    parameter int LOW_CYCLES  = 5
) (
    input  wire logic i_mclk,
    input  wire logic i_reset_n,
    input  wire logic i_run,
    output logic      o_data
);
    int count;

    // ----------------------------------------
    // Pulse train
    // ----------------------------------------
    // A stopped source idles low, so a stall never looks like a rising edge.
    // Every run starts with the high phase, which gives the block a clean first pulse.
    always_ff @(posedge i_mclk)
    begin
        if (!i_reset_n || !i_run)
        begin
            o_data <= 1'b0;
            count  <= 0;
        end
        else
        begin
            o_data <= (count < HIGH_CYCLES);
            count  <= (count == HIGH_CYCLES + LOW_CYCLES - 1) ? 0 : count + 1;
        end
    end
endmodule // pwm_source

`default_nettype wire

// ### tb_top.sv
// Self-checking testbench of the waveform steering and shutdown block.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import wss_pkg::*;

    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic        i_mclk;
    logic        i_reset_n;
    logic [2:0]  i_addr;
    logic [7:0]  i_wdata;
    logic        i_wr;
    logic        i_rd;
    logic        i_data;
    logic [5:0]  i_shutdown_n;
    logic [7:0]  o_rdata;
    pin_drive_t  o_pins;
    logic        o_keep_fast_osc;
    logic        run;
    logic        h1;
    logic        h2;
    logic [7:0]  rv;
    int          n_errors;
    int          compares;

    waveform_steering_shutdown dut (
        .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .i_data(i_data), .i_shutdown_n(i_shutdown_n),
        .o_rdata(o_rdata), .o_pins(o_pins), .o_keep_fast_osc(o_keep_fast_osc)
    );

    pwm_source src (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_run(run), .o_data(i_data));

    // Clock at 100 MHz.
    initial
    begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    // Input history matching the block's sample flop plus output flop.
    always @(posedge i_mclk)
    begin
        h1 <= i_data;
        h2 <= h1;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so it is taken there.
    task automatic rd(input logic [2:0] a);
        @(posedge i_mclk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd   <= 1'b0;
        @(negedge i_mclk);
        rv = o_rdata;
    endtask

    // Source run and fault levels change only just after a rising edge.
    task automatic set_in(input logic r, input logic [5:0] s);
        @(posedge i_mclk);
        run          <= r;
        i_shutdown_n <= s;
    endtask

    // All four pins driven, levels as given.
    task automatic pins(input string name, input logic [3:0] lvl);
        @(negedge i_mclk);
        chk(name, o_pins, {lvl, 4'h0});
    endtask

    // Steered pins follow the input two edges late; the others stay driven low.
    task automatic watch(input int n, input logic [3:0] steer, input logic [3:0] pol);
        repeat (n)
        begin
            @(negedge i_mclk);
            chk("steered pins", o_pins, {steer & ({4{h2}} ^ pol), 4'h0});
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Reset values, then setup in the safe order and steering of A and C.
    task automatic t_setup_steer;
        chk("pins in reset", o_pins, 8'h0F);
        rd(3'h4); chk("shutdown_control_zero", rv, 8'h14);
        rd(3'h5); chk("shutdown_source_select", rv, 8'h80);
        wr(3'h0, 8'h00);
        wr(3'h2, 8'h03);
        wr(3'h3, 8'h02);
        wr(3'h5, 8'h01);
        wr(3'h4, 8'hB8);
        wr(3'h1, 8'h01);
        wr(3'h6, 8'h05);
        wr(3'h0, 8'hC0);
        rd(3'h0); chk("load with enable", rv, 8'h80);
        pins("start in shutdown", 4'h0);
        wr(3'h4, 8'h38);
        set_in(1'b1, 6'h3F);
        cyc(12);
        watch(16, 4'h5, 4'h1);
    endtask

    // Immediate steering in mode 000, deferred steering in mode 001.
    task automatic t_steer_timing;
        set_in(1'b0, 6'h3F);
        cyc(10);
        wr(3'h1, 8'h02);
        wr(3'h6, 8'h02);
        cyc(3);
        pins("async steer", 4'h2);
        wr(3'h6, 8'h00);
        wr(3'h0, 8'h81);
        wr(3'h6, 8'h02);
        cyc(5);
        pins("sync steer held", 4'h0);
        set_in(1'b1, 6'h3F);
        cyc(12);
        watch(8, 4'h2, 4'h2);
    endtask

    // Fault on a selected source; refused clear; hold until a rising edge.
    task automatic t_fault;
        wr(3'h0, 8'h80);
        wr(3'h1, 8'h01);
        wr(3'h6, 8'h05);
        set_in(1'b0, 6'h3D);
        cyc(10);
        pins("unselected fault", 4'h1);
        set_in(1'b0, 6'h3E);
        cyc(2);
        pins("fault override", 4'h0);
        rd(3'h4); chk("shutdown set", rv, 8'hB8);
        wr(3'h4, 8'h38);
        rd(3'h4); chk("clear refused", rv, 8'hB8);
        set_in(1'b0, 6'h3F);
        wr(3'h4, 8'h38);
        rd(3'h4); chk("clear taken", rv, 8'h38);
        cyc(4);
        pins("override until rise", 4'h0);
        set_in(1'b1, 6'h3F);
        cyc(12);
        watch(8, 4'h5, 4'h1);
    endtask

    // Auto-restart after a fault and after a software shutdown.
    task automatic t_restart;
        wr(3'h4, 8'h78);
        set_in(1'b1, 6'h3E);
        cyc(3);
        rd(3'h4); chk("fault with restart", rv, 8'hF8);
        set_in(1'b1, 6'h3F);
        cyc(3);
        rd(3'h4); chk("auto clear", rv, 8'h78);
        wr(3'h4, 8'hF8);
        cyc(2);
        rd(3'h4); chk("soft auto clear", rv, 8'h78);
        cyc(12);
        watch(8, 4'h5, 4'h1);
    endtask

    // Full-bridge direction change waits a rising edge; reserved code is inert.
    task automatic t_bridge;
        wr(3'h1, 8'h00);
        wr(3'h4, 8'h38);
        wr(3'h0, 8'h82);
        cyc(20);
        set_in(1'b0, 6'h3F);
        cyc(10);
        pins("forward", 4'h1);
        wr(3'h0, 8'h83);
        cyc(6);
        pins("direction held", 4'h1);
        set_in(1'b1, 6'h3F);
        cyc(3);
        pins("first pulse blanked", 4'h4);
        cyc(8);
        pins("second pulse", 4'h6);
        set_in(1'b0, 6'h3F);
        cyc(10);
        pins("reverse", 4'h4);
        wr(3'h0, 8'h86);
        cyc(4);
        pins("reserved mode", 4'h0);
    endtask

    // Counts high cycles per pin over n cycles; A and B must never be high together.
    task automatic tally(input int n, input int ea, input int eb);
        int ca = 0;
        int cb = 0;
        int cc = 0;
        int cd = 0;
        repeat (n)
        begin
            @(negedge i_mclk);
            ca += o_pins.level[0];
            cb += o_pins.level[1];
            cc += o_pins.level[2];
            cd += o_pins.level[3];
            chk("a b overlap", {7'h00, o_pins.level[0] & o_pins.level[1]}, 8'h00);
        end
        chk("a high cycles", 8'(ca), 8'(ea));
        chk("b high cycles", 8'(cb), 8'(eb));
        chk("c high cycles", 8'(cc), 8'(ea));
        chk("d high cycles", 8'(cd), 8'(eb));
    endtask

    // Half-bridge dead band of one clock each side, a fault there, then push-pull from A.
    task automatic t_half_push;
        wr(3'h2, 8'h01);
        wr(3'h3, 8'h01);
        wr(3'h1, 8'h00);
        wr(3'h4, 8'h28);
        wr(3'h0, 8'h84);
        cyc(30);
        tally(8, 2, 4);
        set_in(1'b1, 6'h3E);
        cyc(2);
        pins("half fault", 4'h0);
        set_in(1'b1, 6'h3F);
        wr(3'h4, 8'h28);
        wr(3'h0, 8'h05);
        wr(3'h0, 8'h85);
        for (int k = 0; k < 40 && o_pins.level[1:0] == 2'h0; k++)
            @(negedge i_mclk);
        chk("first pulse", {6'h00, o_pins.level[1:0]}, 8'h01);
        tally(16, 3, 3);
    endtask

    // Oscillator request, load bit self-clear, and release of the pins.
    task automatic t_osc_load;
        wr(3'h0, 8'h80);
        wr(3'h7, 8'h01);
        wr(3'h0, 8'hC0);
        rd(3'h0); chk("load pending", rv, 8'hC0);
        set_in(1'b1, 6'h3F);
        cyc(20);
        @(negedge i_mclk);
        chk("keep osc", {7'h00, o_keep_fast_osc}, 8'h01);
        rd(3'h0); chk("load cleared", rv, 8'h80);
        wr(3'h7, 8'h00);
        cyc(3);
        @(negedge i_mclk);
        chk("osc released", {7'h00, o_keep_fast_osc}, 8'h00);
        wr(3'h0, 8'h00);
        cyc(3);
        @(negedge i_mclk);
        chk("disabled pins", {4'h0, o_pins.oe_n}, 8'h0F);
    endtask

    // ----------------------------------------
    // Run control
    // ----------------------------------------
    task automatic finish_test;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // A hang is cut short well beyond the four hundred or so cycles the run needs.
    initial
    begin
        cyc(5000);
        n_errors++;
        finish_test;
    end

    // Main sequence.
    initial
    begin
        i_reset_n    = 1'b0;
        i_addr       = 3'h0;
        i_wdata      = 8'h00;
        i_wr         = 1'b0;
        i_rd         = 1'b0;
        i_shutdown_n = 6'h3F;
        run          = 1'b0;
        n_errors     = 0;
        compares     = 0;
        cyc(20);
        i_reset_n <= 1'b1;
        t_setup_steer;
        t_steer_timing;
        t_fault;
        t_restart;
        t_bridge;
        t_osc_load;
        t_half_push;
        finish_test;
    end
endmodule // tb_top

`default_nettype wire
